// ---- inc/dsos_map.svh ----
// Register offsets, field positions, reset values, function codes and timing for the output selector
`ifndef DSOS_MAP_SVH
`define DSOS_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define DSOS_REG_SEL0        8'h00
`define DSOS_REG_SEL5        8'h05
`define DSOS_REG_FAULT_MASK  8'h06
`define DSOS_REG_POLARITY    8'h07
`define DSOS_REG_GEN_ON      8'h08
`define DSOS_REG_GEN_OFF     8'h09
`define DSOS_REG_FAULT_ON    8'h0a
`define DSOS_REG_FAULT_OFF   8'h0b
`define DSOS_REG_FOLLOW_ON   8'h0c
`define DSOS_REG_FOLLOW_OFF  8'h0d
`define DSOS_REG_APP_MODE    8'h0e
`define DSOS_REG_CTRL_MODE   8'h0f
`define DSOS_REG_ZS_THR      8'h10
`define DSOS_REG_ZS_WIN      8'h11
`define DSOS_REG_TQ_THR      8'h12
`define DSOS_REG_TQ_WIN      8'h13
`define DSOS_REG_IN_SEL      8'h14
`define DSOS_REG_STATUS      8'h15

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DSOS_IN_SEL_TIMER_LSB 0
`define DSOS_IN_SEL_XCHG_LSB  4
`define DSOS_ST_FAULT_BIT     8
`define DSOS_ST_TIMER_BIT     9
`define DSOS_RST_SEL_RELAY1   6'h1d
`define DSOS_RST_SEL_RELAY2   6'h0e
`define DSOS_RST_SEL_COLL     6'h01
`define DSOS_RST_FAULT_MASK   3'h2
`define DSOS_RST_ZS_THR       16'h00c8
`define DSOS_RST_ZS_WIN       16'h0064
`define DSOS_RST_TQ_THR       16'h03e8
`define DSOS_RST_TQ_WIN       16'h0032
`define DSOS_APP_TRAVERSE     3'h1
`define DSOS_APP_MMC          3'h3
`define DSOS_CTRL_SENSORLESS  3'h3
`define DSOS_CTRL_VECTOR      3'h4

// ----------------------------------------------------------------
// Output function codes
// ----------------------------------------------------------------
`define DSOS_FN_OVERHEAT   6'h0c
`define DSOS_FN_CMD_LOSS   6'h0d
`define DSOS_FN_RUN        6'h0e
`define DSOS_FN_STOP       6'h0f
`define DSOS_FN_STEADY     6'h10
`define DSOS_FN_LINE_DRV   6'h11
`define DSOS_FN_LINE_MAINS 6'h12
`define DSOS_FN_SPD_SRCH   6'h13
`define DSOS_FN_STEP       6'h14
`define DSOS_FN_SEQ        6'h15
`define DSOS_FN_READY      6'h16
`define DSOS_FN_TRAVERSE_ACCEL_FLAG    6'h17
`define DSOS_FN_TRV_DEC    6'h18
`define DSOS_FN_MMC        6'h19
`define DSOS_FN_ZSPD       6'h1a
`define DSOS_FN_TORQUE     6'h1b
`define DSOS_FN_TIMER      6'h1c
`define DSOS_FN_FAULT      6'h1d
`define DSOS_FN_ENC_TUNE   6'h20
`define DSOS_FN_ENC_DIR    6'h21

// ----------------------------------------------------------------
// Timing: delay tick length and core clock rate
// ----------------------------------------------------------------
`define DSOS_TICK_MS  10
`define DSOS_CLK_KHZ  200000

`endif

// ---- inc/dsos_pkg.sv ----
// Types shared by the drive status output selector
package dsos_pkg;

	typedef logic [5:0]  dsos_code_type;  // Output function code
	typedef logic [15:0] dsos_time_type;  // Delay in 10 ms ticks

	// Drive conditions presented by the drive core
	typedef struct packed {
		logic        overheat;
		logic        cmd_loss;
		logic        run_cmd;
		logic        volt_out;
		logic        dc_brake;
		logic        steady;
		logic        line_drive;
		logic        line_mains;
		logic        speed_search;
		logic        step_pulse;
		logic        seq_pulse;
		logic        healthy;
		logic        traverse_accel_flag;
		logic        trv_dec;
		logic [2:0]  mmc_req;
		logic        autotune;
		logic        enc_board;
		logic        enc_fb_sel;
		logic        enc_dir_err;
		logic        flt_undervolt;
		logic        flt_other;
		logic        flt_restart;
		logic [15:0] speed;
		logic [15:0] torque;
	} dsos_drive_type;

	// Register bus request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} dsos_bus_type;

	// Module state apart from the reset and fault-reset first-stage flops
	typedef struct packed {
		dsos_code_type [5:0] sel_q;
		logic [2:0]          fmask_q;
		logic [5:0]          pol_q;
		dsos_time_type [5:0] dly_q;
		logic [2:0]          app_q;
		logic [2:0]          ctrl_q;
		logic [15:0]         zs_thr_q;
		logic [15:0]         zs_win_q;
		logic [15:0]         tq_thr_q;
		logic [15:0]         tq_win_q;
		logic [2:0]          tsel_q;
		logic [2:0]          xsel_q;
		logic [7:0]          din_m_q;
		logic [7:0]          din_s_q;
		logic [1:0]          frst_q;
		logic                zs_q;
		logic                tq_q;
		logic                flt_q;
		logic [31:0]         tick_q;
		logic [6:0]          filt_q;
		dsos_time_type [6:0] cnt_q;
		logic [5:0]          do_q;
		logic                xchg_q;
		logic [31:0]         rdata_q;
	} dsos_state_type;

endpackage

// ---- src/dsos_top.sv ----
// Drive status output selector: per-output function decode, delays, fault reporting and polarity
//
// Operation
// - Overheat code follows fan overheat condition.
// - Command-loss code flags lost reference or command.
// - Running code on under voltage, not braking.
// - Stopped code: run off and no voltage.
// - Steady code flags constant motor speed.
// - Two codes give bypass drive/mains selection.
// - Speed-search code active during search.
// - Step and cycle pulses of auto-sequence.
// - Ready code: healthy, idle, awaiting run.
// - Traverse accel and decel reached codes.
// - Multi-motor code only with application three.
// - Zero-speed flag under vector control, hysteresis.
// - Low-torque flag under sensorless/vector, hysteresis.
// - Timer code follows input with delays.
// - Encoder-tune warning: board or feedback missing.
// - Encoder-direction warning during auto-tuning.
// - Fault code active on drive fault.
// - Three-bit mask selects reported fault classes.
// - Fault on-delay; off-delay after reset input.
// - Extension card relays may report faults too.
// - General delays apply except fault outputs.
// - Per-output polarity bit: normally open/closed.
`timescale 1ns/1ps
`include "dsos_map.svh"

module dsos_top #(
	parameter int unsigned P_TICK_CYC = `DSOS_TICK_MS * `DSOS_CLK_KHZ  // Core cycles per delay tick
) (
	input  wire logic                 i_core_clk,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_clk_en,
	input  wire dsos_pkg::dsos_bus_type   i_bus,
	input  wire dsos_pkg::dsos_drive_type i_drive,
	input  wire logic                 i_ext_card,
	input  wire logic [7:0]           i_din,
	input  wire logic                 i_fault_reset,
	output logic [31:0]               o_rdata,
	output logic [5:0]                o_do,
	output logic                      o_xchg_req
);
	import dsos_pkg::*;

	// ----------------------------------------------------------------
	// Reset release synchroniser
	// ----------------------------------------------------------------
	logic [1:0]     rst_sync_q;  // Two-stage release
	logic           rst_n;       // Synchronised reset
	dsos_state_type st_q;        // Registered state
	dsos_state_type st_d;        // Next state

	// Synchronous release keeps all flops leaving reset together
	// Assertion stays immediate so outputs drop at once
	// Reset asserts at once and releases after two edges
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// Combinational helpers
	// ----------------------------------------------------------------
	logic        tick;         // One-cycle 10 ms tick
	logic        timer_in;     // Selected timer input
	logic        flt_event;    // Masked fault present
	logic        frst_edge;    // Fault reset rising edge
	logic        running;      // Drive producing voltage under run
	logic [6:0]  raw;          // Undelayed channel conditions
	logic [5:0]  is_fault;     // Output carries fault code
	logic [31:0] zs_hi;        // Zero-speed release level
	logic [31:0] tq_hi;        // Low-torque release level

	// One struct holds all state but the reset and fault-reset first-stage flops; this process has no memory
	// It only computes the copy that the state register takes
	// Next state: bus, synchronisers, flags, function decode and delays
	always_comb begin
		dsos_time_type dly_on;
		dsos_time_type dly_off;
		dsos_time_type dly;
		logic          fn;
		dly_on    = '0;
		dly_off   = '0;
		dly       = '0;
		fn        = 1'b0;
		st_d      = st_q;
		tick      = (st_q.tick_q == P_TICK_CYC - 1);
		running   = i_drive.run_cmd & i_drive.volt_out;
		timer_in  = st_q.din_s_q[st_q.tsel_q];
		frst_edge = st_q.frst_q[0] & ~st_q.frst_q[1];
		zs_hi     = 32'(st_q.zs_thr_q) + 32'(st_q.zs_win_q);
		tq_hi     = 32'(st_q.tq_thr_q) + 32'(st_q.tq_win_q);
		raw       = '0;
		is_fault  = '0;

		// The first stage may go metastable; only the second is read
		// Input pins pass two flip-flops before use
		st_d.din_m_q = i_din;
		st_d.din_s_q = st_q.din_m_q;
		st_d.frst_q  = {st_q.frst_q[0], st_d.frst_q[0]};

		// One shared divider keeps all channels on one 10 ms grid
		// A delay of N ticks ends within one tick of N x 10 ms
		// Tick divider for all delay counters
		st_d.tick_q = tick ? 32'h0 : st_q.tick_q + 32'h1;

		// A class with its mask bit clear never reaches the latch
		// Fault classes gated by mask: bit0 undervolt, bit1 other, bit2 restart
		flt_event = (st_q.fmask_q[0] & i_drive.flt_undervolt)
			| (st_q.fmask_q[1] & i_drive.flt_other)
			| (st_q.fmask_q[2] & i_drive.flt_restart);

		// The latch keeps a brief fault visible until reset
		// A fault in the reset cycle keeps the latch set
		// Fault latch: a new fault wins over a reset in the same cycle
		if (flt_event) begin
			st_d.flt_q = 1'b1;
		end else if (frst_edge) begin
			st_d.flt_q = 1'b0;
		end

		// The window gives hysteresis against speed noise
		// Clear only at or above threshold plus window
		// Zero-speed flag with release window, vector control, while running
		if (st_q.ctrl_q != `DSOS_CTRL_VECTOR || !running) begin
			st_d.zs_q = 1'b0;
		end else if (i_drive.speed < st_q.zs_thr_q) begin
			st_d.zs_q = 1'b1;
		end else if (32'(i_drive.speed) >= zs_hi) begin
			st_d.zs_q = 1'b0;
		end

		// Same hysteresis scheme as the zero-speed flag
		// Low-torque flag with release window, sensorless or vector
		if (st_q.ctrl_q != `DSOS_CTRL_SENSORLESS && st_q.ctrl_q != `DSOS_CTRL_VECTOR) begin
			st_d.tq_q = 1'b0;
		end else if (i_drive.torque < st_q.tq_thr_q) begin
			st_d.tq_q = 1'b1;
		end else if (32'(i_drive.torque) >= tq_hi) begin
			st_d.tq_q = 1'b0;
		end

		// Level only; outside sequence logic does the changeover
		// Exchange request from the selected digital input
		st_d.xchg_q = st_q.din_s_q[st_q.xsel_q];

		// One code may drive several outputs at once
		// Codes outside the list fall to the default branch
		// Per-output function decode
		for (int k = 0; k < 6; k++) begin
			case (st_q.sel_q[k])
				`DSOS_FN_OVERHEAT:   fn = i_drive.overheat;
				`DSOS_FN_CMD_LOSS:   fn = i_drive.cmd_loss;
				`DSOS_FN_RUN:        fn = running & ~i_drive.dc_brake;
				`DSOS_FN_STOP:       fn = ~i_drive.run_cmd & ~i_drive.volt_out;
				`DSOS_FN_STEADY:     fn = i_drive.steady;
				`DSOS_FN_LINE_DRV:   fn = i_drive.line_drive;
				`DSOS_FN_LINE_MAINS: fn = i_drive.line_mains;
				`DSOS_FN_SPD_SRCH:   fn = i_drive.speed_search;
				`DSOS_FN_STEP:       fn = i_drive.step_pulse;
				`DSOS_FN_SEQ:        fn = i_drive.seq_pulse;
				`DSOS_FN_READY:      fn = i_drive.healthy & ~i_drive.run_cmd & ~i_drive.volt_out;
				// Traverse flags only in traverse application
				`DSOS_FN_TRAVERSE_ACCEL_FLAG:    fn = (st_q.app_q == `DSOS_APP_TRAVERSE) & i_drive.traverse_accel_flag;
				`DSOS_FN_TRV_DEC:    fn = (st_q.app_q == `DSOS_APP_TRAVERSE) & i_drive.trv_dec;
				// Multi-motor only on the three base outputs
				`DSOS_FN_MMC:        fn = (k < 3) && (st_q.app_q == `DSOS_APP_MMC)
					&& i_drive.mmc_req[k % 3];
				`DSOS_FN_ZSPD:       fn = st_q.zs_q;
				`DSOS_FN_TORQUE:     fn = st_q.tq_q;
				`DSOS_FN_TIMER:      fn = st_q.filt_q[6];
				`DSOS_FN_FAULT: begin
					fn          = st_q.flt_q;
					is_fault[k] = 1'b1;
				end
				`DSOS_FN_ENC_TUNE:   fn = i_drive.autotune
					& (~i_drive.enc_board | ~i_drive.enc_fb_sel);
				`DSOS_FN_ENC_DIR:    fn = i_drive.autotune & i_drive.enc_board
					& i_drive.enc_fb_sel & i_drive.enc_dir_err;
				default:             fn = 1'b0;
			endcase
			// Extension relays only exist with the card fitted
			raw[k] = (k < 3) ? fn : (fn & i_ext_card);
		end
		// Follower channel takes the synchronised input directly
		raw[6] = timer_in;

		// A timer output passes follow delays, then general delays
		// Fault outputs use their own pair of delays
		// Delay channels: six outputs and the timer follower
		for (int c = 0; c < 7; c++) begin
			if (c == 6) begin
				dly_on  = st_q.dly_q[4];
				dly_off = st_q.dly_q[5];
			end else if (is_fault[c]) begin
				dly_on  = st_q.dly_q[2];
				dly_off = st_q.dly_q[3];
			end else begin
				dly_on  = st_q.dly_q[0];
				dly_off = st_q.dly_q[1];
			end
			// The delay towards the new level applies
			dly = raw[c] ? dly_on : dly_off;
			if (raw[c] == st_q.filt_q[c]) begin
				// Condition matches output: any pending count restarts
				st_d.cnt_q[c] = '0;
			end else if (dly == '0 || (tick && st_q.cnt_q[c] >= dly - 16'h1)) begin
				// Delay expired: take the new level
				st_d.filt_q[c] = raw[c];
				st_d.cnt_q[c]  = '0;
			end else if (tick) begin
				st_d.cnt_q[c] = st_q.cnt_q[c] + 16'h1;
			end
		end

		// Polarity last, so a closed contact idles high
		// Output stage with polarity; absent extension relays stay off
		for (int k = 0; k < 6; k++) begin
			st_d.do_q[k] = (k >= 3 && !i_ext_card) ? 1'b0
				: (st_q.filt_q[k] ^ st_q.pol_q[k]);
		end

		// Unmapped words and the status word ignore writes
		// A write lands at the edge that samples its strobe
		// Register writes
		if (i_bus.wr) begin
			if (i_bus.addr <= `DSOS_REG_SEL5) begin
				st_d.sel_q[i_bus.addr[2:0]] = i_bus.wdata[5:0];
			end else if (i_bus.addr == `DSOS_REG_FAULT_MASK) begin
				st_d.fmask_q = i_bus.wdata[2:0];
			end else if (i_bus.addr == `DSOS_REG_POLARITY) begin
				st_d.pol_q = i_bus.wdata[5:0];
			end else if (i_bus.addr >= `DSOS_REG_GEN_ON && i_bus.addr <= `DSOS_REG_FOLLOW_OFF) begin
				st_d.dly_q[3'(i_bus.addr - `DSOS_REG_GEN_ON)] = i_bus.wdata[15:0];
			end else if (i_bus.addr == `DSOS_REG_APP_MODE) begin
				st_d.app_q = i_bus.wdata[2:0];
			end else if (i_bus.addr == `DSOS_REG_CTRL_MODE) begin
				st_d.ctrl_q = i_bus.wdata[2:0];
			end else if (i_bus.addr == `DSOS_REG_ZS_THR) begin
				st_d.zs_thr_q = i_bus.wdata[15:0];
			end else if (i_bus.addr == `DSOS_REG_ZS_WIN) begin
				st_d.zs_win_q = i_bus.wdata[15:0];
			end else if (i_bus.addr == `DSOS_REG_TQ_THR) begin
				st_d.tq_thr_q = i_bus.wdata[15:0];
			end else if (i_bus.addr == `DSOS_REG_TQ_WIN) begin
				st_d.tq_win_q = i_bus.wdata[15:0];
			end else if (i_bus.addr == `DSOS_REG_IN_SEL) begin
				st_d.tsel_q = i_bus.wdata[`DSOS_IN_SEL_TIMER_LSB +: 3];
				st_d.xsel_q = i_bus.wdata[`DSOS_IN_SEL_XCHG_LSB +: 3];
			end
		end

		// Unmapped words read as zero
		// Register reads: data stands in the following cycle only
		st_d.rdata_q = 32'h0;
		if (i_bus.rd) begin
			if (i_bus.addr <= `DSOS_REG_SEL5) begin
				st_d.rdata_q = {26'h0, st_q.sel_q[i_bus.addr[2:0]]};
			end else if (i_bus.addr == `DSOS_REG_FAULT_MASK) begin
				st_d.rdata_q = {29'h0, st_q.fmask_q};
			end else if (i_bus.addr == `DSOS_REG_POLARITY) begin
				st_d.rdata_q = {26'h0, st_q.pol_q};
			end else if (i_bus.addr >= `DSOS_REG_GEN_ON && i_bus.addr <= `DSOS_REG_FOLLOW_OFF) begin
				st_d.rdata_q = {16'h0, st_q.dly_q[3'(i_bus.addr - `DSOS_REG_GEN_ON)]};
			end else if (i_bus.addr == `DSOS_REG_APP_MODE) begin
				st_d.rdata_q = {29'h0, st_q.app_q};
			end else if (i_bus.addr == `DSOS_REG_CTRL_MODE) begin
				st_d.rdata_q = {29'h0, st_q.ctrl_q};
			end else if (i_bus.addr == `DSOS_REG_ZS_THR) begin
				st_d.rdata_q = {16'h0, st_q.zs_thr_q};
			end else if (i_bus.addr == `DSOS_REG_ZS_WIN) begin
				st_d.rdata_q = {16'h0, st_q.zs_win_q};
			end else if (i_bus.addr == `DSOS_REG_TQ_THR) begin
				st_d.rdata_q = {16'h0, st_q.tq_thr_q};
			end else if (i_bus.addr == `DSOS_REG_TQ_WIN) begin
				st_d.rdata_q = {16'h0, st_q.tq_win_q};
			end else if (i_bus.addr == `DSOS_REG_IN_SEL) begin
				st_d.rdata_q = {25'h0, st_q.xsel_q, 1'b0, st_q.tsel_q};
			end else if (i_bus.addr == `DSOS_REG_STATUS) begin
				// Live output levels, fault latch and timer follower
				st_d.rdata_q = {22'h0, st_q.filt_q[6], st_q.flt_q, 2'h0, st_q.do_q};
			end
		end
	end

	// Fault reset pin first stage; second stage and edge use frst_q[1:0]
	logic frst_m_q;  // Fault reset first synchroniser stage

	// Only this flop sees the raw pin; the rest is in the struct
	// First synchroniser stage for the fault reset pin
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frst_m_q <= 1'b0;
		end else if (i_clk_en) begin
			frst_m_q <= i_fault_reset;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	dsos_state_type st_n;  // State with synchroniser stage inserted

	// Feed the fault reset second stage from its first stage only
	always_comb begin
		st_n           = st_d;
		st_n.frst_q[0] = frst_m_q;
	end

	// Relay one resets to the fault code, relay two to running
	// Collector select, fault mask and detector levels take map values; the rest starts cleared
	// Registers the state struct; clock enable low freezes it
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q          <= '0;
			st_q.sel_q[0] <= `DSOS_RST_SEL_RELAY1;
			st_q.sel_q[1] <= `DSOS_RST_SEL_RELAY2;
			st_q.sel_q[2] <= `DSOS_RST_SEL_COLL;
			st_q.fmask_q  <= `DSOS_RST_FAULT_MASK;
			st_q.zs_thr_q <= `DSOS_RST_ZS_THR;
			st_q.zs_win_q <= `DSOS_RST_ZS_WIN;
			st_q.tq_thr_q <= `DSOS_RST_TQ_THR;
			st_q.tq_win_q <= `DSOS_RST_TQ_WIN;
		end else if (i_clk_en) begin
			st_q <= st_n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs straight from state flip-flops
	// ----------------------------------------------------------------
	// No logic between these flip-flops and the pins
	assign o_rdata    = st_q.rdata_q;
	assign o_do       = st_q.do_q;
	assign o_xchg_req = st_q.xchg_q;

endmodule // dsos_top

// ---- verif/dsos_top_sva.sv ----
// Port checker for the drive status output selector
`timescale 1ns/1ps

module dsos_top_sva (
	input wire logic                   i_core_clk,
	input wire logic                   i_arst_n,
	input wire dsos_pkg::dsos_bus_type i_bus,
	input wire logic                   i_ext_card,
	input wire logic [7:0]             i_din,
	input wire logic [31:0]            o_rdata,
	input wire logic [5:0]             o_do,
	input wire logic                   o_xchg_req
);
	import dsos_pkg::*;

	// ----------------------------------------------------------------
	// One clock domain, reset disables every check
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	// Read data only in the slot after a read
	rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
		else $error("read data outside its slot");
	// Status word mirrors the outputs, upper bits zero
	status_mirror_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) == 8'h15
		|-> o_rdata[5:0] == $past(o_do) && o_rdata[31:10] == 22'h0)
		else $error("status word wrong");
	// Unmapped words read as zero
	unmapped_zero_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) > 8'h15 |-> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	// Select codes are six bits wide
	sel_width_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) <= 8'h05
		|-> o_rdata[31:6] == 26'h0) else $error("select word too wide");
	// Fault class mask is three bits wide
	mask_width_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) == 8'h06
		|-> o_rdata[31:3] == 29'h0) else $error("mask word too wide");
	// Polarity word holds six bits
	pol_width_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) == 8'h07
		|-> o_rdata[31:6] == 26'h0) else $error("polarity word too wide");
	// Card relays stay off while no card is fitted
	ext_off_a: assert property (!i_ext_card [*2] |=> o_do[5:3] == 3'h0)
		else $error("card relay active without card");
	// Changeover request low once all inputs settled low
	xchg_low_a: assert property (i_din == 8'h00 [*4] |=> !o_xchg_req)
		else $error("changeover request without input");
endmodule // dsos_top_sva

// ---- verif/dsos_relay_model.sv ----
// Relay bank and operator reset button wired to the selector terminals
`timescale 1ns/1ps

module dsos_relay_model (
	input  wire logic       i_clk,
	input  wire logic       i_press,
	input  wire logic [5:0] i_coil,
	output logic            o_reset_pin,
	output logic [5:0]      o_contact
);
	// Reset button reaches the pin one cycle after it is pressed
	always_ff @(posedge i_clk) begin
		o_reset_pin <= i_press;
	end
	// Contacts follow the coils; contact type is set on the driving side
	assign o_contact = i_coil;
endmodule // dsos_relay_model

// ---- verif/drive_status_output_selector_tb.sv ----
// Self-checking bench for the drive status output selector
`timescale 1ns/1ps
`include "dsos_map.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %0h seen %0h", n, e, g); end end

module drive_status_output_selector_tb;
	import dsos_pkg::*;
	logic           clk = 1'h0;  // Core clock
	logic           arst_n = 1'h0; // Reset, active low
	logic           ext = 1'h0;  // Extension card fitted
	logic           frq = 1'h0;  // Reset button
	logic [7:0]     din = 8'h00; // Input pins
	dsos_bus_type   bus = '0;    // Register port request
	dsos_drive_type drv = '0;    // Drive conditions
	dsos_drive_type on, off;
	logic [31:0]    rdata;
	logic [5:0]     dout, contact;
	logic           xchg, frst;
	int             failures = 0;
	int             n_compared = 0;
	logic [15:0]    rv [21] = '{0:16'h1d, 1:16'h0e, 2:16'h01, 6:16'h2, 16:16'hc8, 17:16'h64,
		18:16'h3e8, 19:16'h32, default:16'h0};
	logic [5:0]     fc [15] = '{6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13,
		6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h20, 6'h21};

	always #2.5 clk = ~clk;

	dsos_top #(.P_TICK_CYC(4)) dut (.i_core_clk(clk), .i_arst_n(arst_n), .i_clk_en(1'h1),
		.i_bus(bus), .i_drive(drv), .i_ext_card(ext), .i_din(din), .i_fault_reset(frst),
		.o_rdata(rdata), .o_do(dout), .o_xchg_req(xchg));
	dsos_relay_model u_relay (.i_clk(clk), .i_press(frq), .i_coil(dout),
		.o_reset_pin(frst), .o_contact(contact));

	// ----------------------------------------------------------------
	// Register port and timing helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{1'h1, 1'h0, a, d};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		bus <= '{1'h0, 1'h1, a, 32'h0};
		@(posedge clk);
		bus <= '0;
		#1 `CHK(n, e, rdata)
	endtask
	task automatic setd(input dsos_drive_type d);
		@(posedge clk);
		drv <= d;
	endtask
	task automatic look(input int n, input int b, input logic e, input string s);
		cyc(n);
		`CHK(s, e, dout[b])
	endtask
	task automatic press;
		@(posedge clk);
		frq <= 1'h1;
		repeat (3) @(posedge clk);
		frq <= 1'h0;
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'h1;
		cyc(4);
		// Reset values and an unmapped word
		for (int a = 0; a < 21; a++) rd(a[7:0], {16'h0, rv[a]}, "reset value");
		rd(8'h20, 32'h0, "unmapped");
		$display("test reset done");
		// Fifteen status codes each assert on their condition and drop without it
		wr(`DSOS_REG_APP_MODE, 32'h1);
		for (int i = 0; i < 15; i++) begin
			on = '0;
			off = '0;
			case (i)
				0: on.overheat = '1;
				1: on.cmd_loss = '1;
				2: {on.run_cmd, on.volt_out} = 2'h3;
				4: on.steady = '1;
				5: on.line_drive = '1;
				6: on.line_mains = '1;
				7: on.speed_search = '1;
				8: on.step_pulse = '1;
				9: on.seq_pulse = '1;
				10: on.healthy = '1;
				11: on.traverse_accel_flag = '1;
				12: on.trv_dec = '1;
				13: on.autotune = '1;
				14: {on.autotune, on.enc_board, on.enc_fb_sel, on.enc_dir_err} = 4'hf;
				default: ;
			endcase
			case (i)
				2: {off.run_cmd, off.volt_out, off.dc_brake} = 3'h7;
				3: off.volt_out = '1;
				10: {off.healthy, off.run_cmd} = 2'h3;
				13, 14: {off.autotune, off.enc_board, off.enc_fb_sel} = 3'h7;
				default: ;
			endcase
			wr(`DSOS_REG_SEL0, {26'h0, fc[i]});
			setd(on);
			look(3, 0, 1'h1, "code active");
			setd(off);
			look(3, 0, 1'h0, "code idle");
		end
		$display("test codes done");
		// Fault class mask, latch and reset pin
		wr(`DSOS_REG_SEL0, 32'h1d);
		on = '0;
		on.flt_undervolt = '1;
		setd(on);
		look(6, 0, 1'h0, "masked fault");
		wr(`DSOS_REG_FAULT_MASK, 32'h1);
		look(4, 0, 1'h1, "undervolt fault");
		setd('0);
		press();
		look(8, 0, 1'h0, "fault cleared");
		wr(`DSOS_REG_FAULT_MASK, 32'h4);
		on = '0;
		on.flt_restart = '1;
		setd(on);
		look(4, 0, 1'h1, "restart fault");
		setd('0);
		press();
		// Fault delays beside a long general delay
		wr(`DSOS_REG_FAULT_MASK, 32'h2);
		wr(`DSOS_REG_FAULT_ON, 32'h3);
		wr(`DSOS_REG_FAULT_OFF, 32'h2);
		wr(`DSOS_REG_GEN_ON, 32'h32);
		wr(`DSOS_REG_SEL0 + 8'h3, 32'h1d);
		on = '0;
		{on.run_cmd, on.volt_out, on.flt_other} = 3'h7;
		setd(on);
		on.flt_other = '0;
		setd(on);
		look(6, 0, 1'h0, "fault on delay");
		look(16, 0, 1'h1, "fault on");
		`CHK("run general delay", 1'h0, dout[1])
		`CHK("card absent", 1'h0, dout[3])
		ext <= 1'h1;
		look(14, 3, 1'h1, "card fault relay");
		look(200, 1, 1'h1, "run after delay");
		press();
		look(5, 0, 1'h1, "fault off delay");
		look(16, 0, 1'h0, "fault off");
		$display("test fault done");
		// Unassigned code with normally closed contact
		setd('0);
		wr(`DSOS_REG_GEN_ON, 32'h0);
		wr(`DSOS_REG_SEL0 + 8'h2, 32'h0);
		wr(`DSOS_REG_POLARITY, 32'h4);
		look(3, 2, 1'h1, "closed contact");
		`CHK("contact pin", 1'h1, contact[2])
		rd(`DSOS_REG_STATUS, 32'h4, "status");
		wr(`DSOS_REG_POLARITY, 32'h0);
		look(3, 2, 1'h0, "open contact");
		// Multi-motor code gated by application mode
		wr(`DSOS_REG_SEL0, 32'h19);
		on = '0;
		on.mmc_req = 3'h1;
		setd(on);
		look(3, 0, 1'h0, "mmc other mode");
		wr(`DSOS_REG_APP_MODE, 32'h3);
		look(3, 0, 1'h1, "mmc mode");
		// Zero speed and low torque with their windows
		wr(`DSOS_REG_CTRL_MODE, 32'h4);
		wr(`DSOS_REG_SEL0, 32'h1a);
		on = '0;
		{on.run_cmd, on.volt_out, on.speed} = {2'h3, 16'h0064};
		setd(on);
		look(3, 0, 1'h1, "zero speed");
		on.speed = 16'h00fa;
		setd(on);
		look(3, 0, 1'h1, "zero speed window");
		on.speed = 16'h012c;
		setd(on);
		look(3, 0, 1'h0, "speed above window");
		wr(`DSOS_REG_CTRL_MODE, 32'h3);
		wr(`DSOS_REG_SEL0, 32'h1b);
		on.torque = 16'h0384;
		setd(on);
		look(3, 0, 1'h1, "low torque");
		on.torque = 16'h0410;
		setd(on);
		look(3, 0, 1'h1, "torque window");
		on.torque = 16'h041a;
		setd(on);
		look(3, 0, 1'h0, "torque above window");
		$display("test detect done");
		// Timer follower, glitch drop and changeover input
		setd('0);
		wr(`DSOS_REG_IN_SEL, 32'h32);
		wr(`DSOS_REG_SEL0, 32'h1c);
		din <= 8'h04;
		look(6, 0, 1'h1, "timer follow");
		din <= 8'h00;
		look(6, 0, 1'h0, "timer release");
		wr(`DSOS_REG_FOLLOW_ON, 32'h3);
		din <= 8'h04;
		cyc(3);
		din <= 8'h00;
		look(20, 0, 1'h0, "glitch dropped");
		din <= 8'h04;
		look(24, 0, 1'h1, "timer delayed");
		din <= 8'h08;
		cyc(5);
		`CHK("changeover", 1'h1, xchg)
		din <= 8'hf7;
		cyc(5);
		`CHK("changeover other pins", 1'h0, xchg)
		$display("test inputs done");
		conclude();
	end
endmodule // drive_status_output_selector_tb

bind dsos_top dsos_top_sva u_sva (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_bus(i_bus),
	.i_ext_card(i_ext_card), .i_din(i_din), .o_rdata(o_rdata), .o_do(o_do), .o_xchg_req(o_xchg_req));
